// [verilog/avc_pkg.sv]
package avc_pkg;

  localparam int AVC_DATA_W = 32;
  localparam int AVC_WIDE_W = 66;
  localparam int AVC_IRQ_W = 3;

  // Byte offsets of the word registers.
  localparam logic [7:0] AVC_OFS_CTRL = 8'h00;
  localparam logic [7:0] AVC_OFS_ACTUAL = 8'h04;
  localparam logic [7:0] AVC_OFS_SETPOINT = 8'h08;
  localparam logic [7:0] AVC_OFS_ACT_GAIN = 8'h0C;
  localparam logic [7:0] AVC_OFS_SP_GAIN = 8'h10;
  localparam logic [7:0] AVC_OFS_OFFSET = 8'h14;
  localparam logic [7:0] AVC_OFS_HYST = 8'h18;
  localparam logic [7:0] AVC_OFS_STATE = 8'h1C;
  localparam logic [7:0] AVC_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] AVC_OFS_IRQ_CLR = 8'h24;
  localparam logic [7:0] AVC_OFS_IRQ_EN = 8'h28;

  // Control register fields.
  localparam int AVC_CTRL_MODE_LSB = 0;
  localparam int AVC_CTRL_REL_BIT = 2;
  // State register fields.
  localparam int AVC_ST_MATCH_BIT = 0;
  localparam int AVC_ST_OVF_BIT = 1;
  localparam int AVC_ST_EN_BIT = 2;
  // Interrupt event bits.
  localparam int AVC_EV_MATCH_ON = 0;
  localparam int AVC_EV_MATCH_OFF = 1;
  localparam int AVC_EV_OVF_ON = 2;

  localparam logic [31:0] AVC_RST_GAIN = 32'h00000001;
  localparam logic [31:0] AVC_RST_ZERO = 32'h00000000;
  localparam logic [1:0] AVC_HTRANS_NONSEQ = 2'h2;

  localparam logic signed [65:0] AVC_VAL_MIN = 66'sh3FFFFFFFF80000000;
  localparam logic signed [65:0] AVC_VAL_MAX = 66'sh0000000007FFFFFFF;

  typedef enum logic [1:0] {
    AVC_MODE_LESS = 2'h0,
    AVC_MODE_EQUAL = 2'h1,
    AVC_MODE_GREATER = 2'h2
  } avc_mode_type;

  typedef struct packed {
    logic [31:0] actual_value_in;
    logic [31:0] setpoint_in;
    logic [31:0] actual_gain;
    logic [31:0] setpoint_gain;
    logic [31:0] zero_point_offset;
    logic [31:0] hysteresis_band;
  } avc_opnd_type;

  typedef struct packed {
    logic match_contact;
    logic range_overflow_contact;
  } avc_contact_type;

endpackage : avc_pkg

// [verilog/avc_comparator.sv]
// Our own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - With release bit set, act only while enable is high; else run always.
// - Greater mode: on at value reaching setpoint, off below setpoint minus band.
// - Less mode: on at value reaching setpoint, off above setpoint plus band.
// - Signed offset is added to the scaled actual value before comparing.
// - Equal mode: on at equality, off beyond either hysteresis limit.
// - Overflow contact closes while corrected value is out of 32-bit range.
// - No retained state; contacts start inactive after restart.
// - Actual value is multiplied by its signed 32-bit gain.
// - Setpoint is multiplied by its own signed 32-bit gain.
// - Signed 32-bit hysteresis applied above and below the scaled setpoint.
// - Mode is less-than, equal or greater-than.
// - Match contact held at zero while overflow is indicated.
// - Overflow also when setpoint plus or minus band leaves the range.
module avc_comparator (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output avc_pkg::avc_contact_type o_contacts,
  output logic o_irq
);
  import avc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] hrdata_r;
  logic [2:0] ctrl_r;
  avc_opnd_type opnd_r;
  logic [AVC_IRQ_W-1:0] irq_stat_r;
  logic [AVC_IRQ_W-1:0] irq_en_r;
  logic match_r;
  logic ovf_r;

  wire addr_phase = i_hsel && (i_htrans == AVC_HTRANS_NONSEQ) && i_hready;
  wire [7:0] a_ofs = i_haddr[7:0];
  wire wr_ctrl = wr_pend_r && (wr_addr_r == AVC_OFS_CTRL);
  wire wr_act = wr_pend_r && (wr_addr_r == AVC_OFS_ACTUAL);
  wire wr_sp = wr_pend_r && (wr_addr_r == AVC_OFS_SETPOINT);
  wire wr_again = wr_pend_r && (wr_addr_r == AVC_OFS_ACT_GAIN);
  wire wr_sgain = wr_pend_r && (wr_addr_r == AVC_OFS_SP_GAIN);
  wire wr_off = wr_pend_r && (wr_addr_r == AVC_OFS_OFFSET);
  wire wr_hyst = wr_pend_r && (wr_addr_r == AVC_OFS_HYST);
  wire wr_iclr = wr_pend_r && (wr_addr_r == AVC_OFS_IRQ_CLR);
  wire wr_ien = wr_pend_r && (wr_addr_r == AVC_OFS_IRQ_EN);
  wire [31:0] state_word = {29'h0, i_enable, ovf_r, match_r};

  // Unmapped and write-only offsets read as zero; every transfer is OKAY.
  wire [31:0] rd_mux =
    (a_ofs == AVC_OFS_CTRL) ? {29'h0, ctrl_r} :
    (a_ofs == AVC_OFS_ACTUAL) ? opnd_r.actual_value_in :
    (a_ofs == AVC_OFS_SETPOINT) ? opnd_r.setpoint_in :
    (a_ofs == AVC_OFS_ACT_GAIN) ? opnd_r.actual_gain :
    (a_ofs == AVC_OFS_SP_GAIN) ? opnd_r.setpoint_gain :
    (a_ofs == AVC_OFS_OFFSET) ? opnd_r.zero_point_offset :
    (a_ofs == AVC_OFS_HYST) ? opnd_r.hysteresis_band :
    (a_ofs == AVC_OFS_STATE) ? state_word :
    (a_ofs == AVC_OFS_IRQ_STAT) ? {29'h0, irq_stat_r} :
    (a_ofs == AVC_OFS_IRQ_EN) ? {29'h0, irq_en_r} : 32'h00000000;

  // Read data is latched at the address phase, so the slave never stalls.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= addr_phase && i_hwrite;
      wr_addr_r <= a_ofs;
      hrdata_r <= (addr_phase && !i_hwrite) ? rd_mux : hrdata_r;
    end
  end

  assign o_hrdata = hrdata_r;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= 3'h0;
      opnd_r <= {AVC_RST_ZERO, AVC_RST_ZERO, AVC_RST_GAIN, AVC_RST_GAIN,
                 AVC_RST_ZERO, AVC_RST_ZERO};
      irq_en_r <= 3'h0;
    end else begin
      if (wr_ctrl) ctrl_r <= i_hwdata[2:0];
      if (wr_act) opnd_r.actual_value_in <= i_hwdata;
      if (wr_sp) opnd_r.setpoint_in <= i_hwdata;
      if (wr_again) opnd_r.actual_gain <= i_hwdata;
      if (wr_sgain) opnd_r.setpoint_gain <= i_hwdata;
      if (wr_off) opnd_r.zero_point_offset <= i_hwdata;
      if (wr_hyst) opnd_r.hysteresis_band <= i_hwdata;
      if (wr_ien) irq_en_r <= i_hwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wide arithmetic.

  logic signed [63:0] act_prod;
  logic signed [63:0] sp_prod;
  logic signed [65:0] act_c;
  logic signed [65:0] sp_c;
  logic signed [65:0] sp_hi;
  logic signed [65:0] sp_lo;

  assign act_prod = $signed(opnd_r.actual_value_in) * $signed(opnd_r.actual_gain);
  assign sp_prod = $signed(opnd_r.setpoint_in) * $signed(opnd_r.setpoint_gain);
  // Sixty-six bits hold any product plus any 32-bit term without wrapping.
  assign act_c = {{2{act_prod[63]}}, act_prod} +
                 {{34{opnd_r.zero_point_offset[31]}}, opnd_r.zero_point_offset};
  assign sp_c = {{2{sp_prod[63]}}, sp_prod};
  assign sp_hi = sp_c + {{34{opnd_r.hysteresis_band[31]}}, opnd_r.hysteresis_band};
  assign sp_lo = sp_c - {{34{opnd_r.hysteresis_band[31]}}, opnd_r.hysteresis_band};

  wire act_oor = (act_c < AVC_VAL_MIN) || (act_c > AVC_VAL_MAX);
  wire hi_oor = (sp_hi < AVC_VAL_MIN) || (sp_hi > AVC_VAL_MAX);
  wire lo_oor = (sp_lo < AVC_VAL_MIN) || (sp_lo > AVC_VAL_MAX);
  wire ovf_c = act_oor || hi_oor || lo_oor;

  ////////////////////////////////////////////////////////////////////////////
  // Switching with hysteresis.

  wire [1:0] mode_code = ctrl_r[AVC_CTRL_MODE_LSB +: 2];
  wire release_cfg = ctrl_r[AVC_CTRL_REL_BIT];
  wire active = !release_cfg || i_enable;
  wire gt_set = (act_c >= sp_c);
  wire gt_keep = (act_c >= sp_lo);
  wire lt_set = (act_c <= sp_c);
  wire lt_keep = (act_c <= sp_hi);
  wire eq_set = (act_c == sp_c);
  wire eq_keep = (act_c <= sp_hi) && (act_c >= sp_lo);

  logic hyst_nxt;
  always_comb begin
    hyst_nxt = 1'b0;
    // A reserved mode code switches the contact off.
    unique case (mode_code)
      AVC_MODE_GREATER: hyst_nxt = match_r ? gt_keep : gt_set;
      AVC_MODE_LESS: hyst_nxt = match_r ? lt_keep : lt_set;
      AVC_MODE_EQUAL: hyst_nxt = match_r ? eq_keep : eq_set;
      default: hyst_nxt = 1'b0;
    endcase
  end

  // Overflow wins over any comparison, so a wrapped product never closes the match contact.
  wire match_nxt = active ? (!ovf_c && hyst_nxt) : match_r;
  wire ovf_nxt = active ? ovf_c : ovf_r;

  // Contacts hold their last value while the block is not released.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      match_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      match_r <= match_nxt;
      ovf_r <= ovf_nxt;
    end
  end

  assign o_contacts = '{match_contact: match_r, range_overflow_contact: ovf_r};

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts.

  // Events are edges of the next contact values, so status rises with the contact itself.
  logic [AVC_IRQ_W-1:0] ev;
  assign ev[AVC_EV_MATCH_ON] = match_nxt && !match_r;
  assign ev[AVC_EV_MATCH_OFF] = !match_nxt && match_r;
  assign ev[AVC_EV_OVF_ON] = ovf_nxt && !ovf_r;
  wire [AVC_IRQ_W-1:0] clr_bits = wr_iclr ? i_hwdata[2:0] : 3'h0;

  // An event in the cycle of its clear keeps the bit set.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) irq_stat_r <= 3'h0;
    else irq_stat_r <= (irq_stat_r & ~clr_bits) | ev;
  end

  assign o_irq = |(irq_stat_r & irq_en_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  // What the contacts showed when the block stopped, for the long-freeze check.
  logic [3:0] frz_cnt_r;
  logic frz_match_r;
  logic frz_ovf_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      frz_cnt_r <= 4'h0;
      frz_match_r <= 1'b0;
      frz_ovf_r <= 1'b0;
    end else if (!active) begin
      frz_cnt_r <= (frz_cnt_r == 4'hF) ? frz_cnt_r : frz_cnt_r + 4'h1;
      frz_match_r <= (frz_cnt_r == 4'h0) ? match_r : frz_match_r;
      frz_ovf_r <= (frz_cnt_r == 4'h0) ? ovf_r : frz_ovf_r;
    end else begin
      frz_cnt_r <= 4'h0;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_release_hold: assert property (release_cfg && !i_enable |=>
    $stable(match_r) && $stable(ovf_r)) else $error("contacts moved while not released");
  a_free_run: assert property (!release_cfg && !i_enable && ovf_c |=> ovf_r)
    else $error("enable input honoured while release bit clear");
  a_gt_switch_on: assert property (active && mode_code == AVC_MODE_GREATER && !ovf_c
    && gt_set |=> match_r) else $error("greater mode failed to switch on");
  a_gt_band_keep: assert property (active && mode_code == AVC_MODE_GREATER && !ovf_c
    && match_r && !gt_set && gt_keep |=> match_r) else $error("greater mode dropped in band");
  a_lt_band_off: assert property (active && mode_code == AVC_MODE_LESS && match_r
    && !lt_keep |=> !match_r) else $error("less mode held above band");
  a_eq_limit_off: assert property (active && mode_code == AVC_MODE_EQUAL
    && match_r && !eq_keep |=> !match_r) else $error("equal mode held beyond band");
  a_ovf_tracks: assert property (active |=> ovf_r == $past(ovf_c))
    else $error("overflow contact does not follow range");
  a_ovf_blocks_match: assert property (ovf_r |-> !match_r)
    else $error("match set during overflow");
  a_band_range: assert property (active && (hi_oor || lo_oor) |=> ovf_r ##1
    (ovf_r || !$past(hi_oor || lo_oor, 1) || !$past(active, 1)))
    else $error("band overflow not flagged");
  a_irq_level: assert property (|(irq_stat_r & irq_en_r) |-> o_irq)
    else $error("enabled status did not raise interrupt");

  // Switching in every mode, overflow release, wide arithmetic, long freeze and reset.
  a_gt_band_off: assert property (active && mode_code == AVC_MODE_GREATER && match_r
    && !gt_keep |=> !match_r) else $error("greater mode held below band");
  a_lt_switch_on: assert property (active && mode_code == AVC_MODE_LESS && !ovf_c
    && lt_set |=> match_r) else $error("less mode failed to switch on");
  a_lt_band_keep: assert property (active && mode_code == AVC_MODE_LESS && !ovf_c
    && match_r && lt_keep |=> match_r) else $error("less mode dropped in band");
  a_eq_switch_on: assert property (active && mode_code == AVC_MODE_EQUAL && !ovf_c
    && eq_set |=> match_r) else $error("equal mode failed to switch on");
  a_eq_band_keep: assert property (active && mode_code == AVC_MODE_EQUAL && !ovf_c
    && match_r && eq_keep |=> match_r) else $error("equal mode dropped in band");
  a_reserved_off: assert property (active && mode_code == 2'h3 |=> !match_r)
    else $error("reserved mode closed the contact");
  a_ovf_release: assert property (active && !ovf_c |=> !ovf_r)
    else $error("overflow contact stayed closed in range");
  a_wide_no_wrap: assert property (act_c[65] == act_c[63] && sp_hi[65] == sp_hi[63]
    && sp_lo[65] == sp_lo[63]) else $error("wide arithmetic wrapped");
  a_freeze_long: assert property (frz_cnt_r != 4'h0 |-> match_r == frz_match_r
    && ovf_r == frz_ovf_r) else $error("contacts drifted during a long freeze");
  a_reset_clear: assert property (disable iff (1'b0) !i_rst_n |-> !match_r
    && !ovf_r && !o_irq && o_hrdata == 32'h00000000)
    else $error("outputs not cleared in reset");

  // Register bus.
  a_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus stalled or answered with an error");
  a_act_lands: assert property (wr_act |=> opnd_r.actual_value_in == $past(i_hwdata))
    else $error("actual value write lost");
  a_sp_lands: assert property (wr_sp |=> opnd_r.setpoint_in == $past(i_hwdata))
    else $error("setpoint write lost");
  a_hyst_lands: assert property (wr_hyst |=> opnd_r.hysteresis_band == $past(i_hwdata))
    else $error("hysteresis write lost");
  a_ctrl_lands: assert property (wr_ctrl |=> ctrl_r == $past(i_hwdata[2:0]))
    else $error("control write lost");
  a_ien_lands: assert property (wr_ien |=> irq_en_r == $past(i_hwdata[2:0]))
    else $error("interrupt enable write lost");
  a_read_ctrl: assert property (addr_phase && !i_hwrite && a_ofs == AVC_OFS_CTRL |=>
    o_hrdata == {29'h0, $past(ctrl_r)}) else $error("control read returned wrong data");

  // Interrupt status.
  a_ev_match_on: assert property (ev[AVC_EV_MATCH_ON] |=> irq_stat_r[AVC_EV_MATCH_ON])
    else $error("match-on event not recorded");
  a_ev_match_off: assert property (ev[AVC_EV_MATCH_OFF] |=> irq_stat_r[AVC_EV_MATCH_OFF])
    else $error("match-off event not recorded");
  a_ev_ovf_on: assert property (ev[AVC_EV_OVF_ON] |=> irq_stat_r[AVC_EV_OVF_ON])
    else $error("overflow event not recorded");
  a_stat_cleared: assert property (wr_iclr && i_hwdata[AVC_EV_MATCH_ON] &&
    !ev[AVC_EV_MATCH_ON] |=> !irq_stat_r[AVC_EV_MATCH_ON]) else $error("status not cleared");
  a_stat_sticky: assert property (irq_stat_r[AVC_EV_OVF_ON] && !wr_iclr |=>
    irq_stat_r[AVC_EV_OVF_ON]) else $error("status bit dropped without a clear");

  c_gt_on: cover property (mode_code == AVC_MODE_GREATER && $rose(match_r));
  c_eq_on: cover property (mode_code == AVC_MODE_EQUAL && $rose(match_r));
  c_ovf_cycle: cover property ($rose(ovf_r) ##[1:20] $fell(ovf_r));
  c_irq_raise: cover property ($rose(o_irq));
  c_lt_on: cover property (mode_code == AVC_MODE_LESS && $rose(match_r));

endmodule : avc_comparator

// [sim/avc_ctrl_prog.sv]
`timescale 1ns/1ps
// Stands in for the control program that drives the release input once per scan.
module avc_ctrl_prog (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_want,
  output logic o_enable
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_enable <= 1'b1;
    end else begin
      o_enable <= i_want;
    end
  end
endmodule : avc_ctrl_prog

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import avc_pkg::*;
  logic i_clk;
  logic i_rst_n;
  logic want, en, hsel, hwrite, hrdy, hresp, irq, m_match, m_ovf;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [31:0] regs [0:10];
  logic [2:0] m_stat;
  avc_contact_type ct;
  int err_count, comparisons, seed, k, r;
  localparam logic [39:0] TBL [0:25] = '{
    {AVC_OFS_IRQ_EN, 32'h7}, {AVC_OFS_CTRL, 32'h2}, {AVC_OFS_SETPOINT, 32'hA},
    {AVC_OFS_HYST, 32'h3}, {AVC_OFS_ACTUAL, 32'hA}, {AVC_OFS_ACTUAL, 32'h8},
    {AVC_OFS_ACTUAL, 32'h6}, {AVC_OFS_OFFSET, 32'h4}, {AVC_OFS_IRQ_CLR, 32'h7},
    {AVC_OFS_CTRL, 32'h0}, {AVC_OFS_ACTUAL, 32'h8}, {AVC_OFS_ACTUAL, 32'hA},
    {AVC_OFS_CTRL, 32'h1}, {AVC_OFS_ACTUAL, 32'h6}, {AVC_OFS_ACTUAL, 32'h8},
    {AVC_OFS_ACTUAL, 32'hA}, {AVC_OFS_CTRL, 32'h2}, {AVC_OFS_ACTUAL, 32'h7FFFFFFF},
    {AVC_OFS_ACTUAL, 32'hA}, {AVC_OFS_ACT_GAIN, 32'h7FFFFFFF}, {AVC_OFS_ACT_GAIN, 32'h1},
    {AVC_OFS_SP_GAIN, 32'h40000000}, {AVC_OFS_SP_GAIN, 32'h1},
    {AVC_OFS_SETPOINT, 32'h7FFFFFFF}, {AVC_OFS_SETPOINT, 32'hA}, {AVC_OFS_CTRL, 32'h3}};

  avc_ctrl_prog i_avc_ctrl_prog (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_want(want), .o_enable(en));
  avc_comparator i_avc_comparator (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_enable(en),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_contacts(ct), .o_irq(irq));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // A bounded wait, so a stuck bus ends the run instead of hanging it.
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      print_verdict();
    end
  endtask : wait_rdy

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= AVC_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk("resp", 32'h0, hresp);
  endtask : ahb

  function automatic logic inr(input longint v);
    return v >= -64'sh80000000 && v <= 64'sh7FFFFFFF;
  endfunction : inr

  // One scan of the model; with a non-negative band a repeated scan changes nothing.
  task automatic upd;
    longint act, sp, hi, lo;
    logic ov, on, keep, nm;
    logic [1:0] md;
    md = regs[0][1:0];
    act = $signed(regs[1]) * $signed(regs[3]) + $signed(regs[5]);
    sp = $signed(regs[2]) * $signed(regs[4]);
    hi = sp + $signed(regs[6]);
    lo = sp - $signed(regs[6]);
    ov = !inr(act) || !inr(hi) || !inr(lo);
    on = (md == 2'h0) ? act <= sp : (md == 2'h1) ? act == sp : (md == 2'h2) ? act >= sp : 1'b0;
    keep = (md == 2'h0) ? act <= hi : (md == 2'h1) ? (act >= lo && act <= hi) :
      (md == 2'h2) ? act >= lo : 1'b0;
    if (!regs[0][2] || en) begin
      nm = !ov && (on || (m_match && keep));
      m_stat = m_stat | {ov && !m_ovf, m_match && !nm, nm && !m_match};
      m_match = nm;
      m_ovf = ov;
    end
  endtask : upd

  // The design scans the old operands while the write is in flight, so the model does too.
  task automatic step(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
    upd();
    if (a == AVC_OFS_IRQ_CLR) m_stat = m_stat & ~d[2:0];
    else regs[a[7:2]] = d;
    @(posedge i_clk);
    #1;
    upd();
    chk("match", m_match, ct.match_contact);
    chk("overflow", m_ovf, ct.range_overflow_contact);
    chk("irq", |(m_stat & regs[10][2:0]), irq);
  endtask : step

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h340E62A7;
    i_rst_n = 1'b0;
    want = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    regs = '{default: 32'h0};
    regs[3] = AVC_RST_GAIN;
    regs[4] = AVC_RST_GAIN;
    {m_match, m_ovf, m_stat, err_count, comparisons} = '0;
    repeat (4) @(posedge i_clk);
    chk("reset contacts", 32'h0, ct);
    i_rst_n <= 1'b1;
    ahb(1'b0, AVC_OFS_ACT_GAIN, 32'h0);
    chk("gain reset", AVC_RST_GAIN, rd);
    step(AVC_OFS_IRQ_EN, 32'h0);
    for (k = 0; k < 26; k++) step(TBL[k][39:32], TBL[k][31:0]);
    step(AVC_OFS_CTRL, 32'h6);
    want <= 1'b0;
    step(AVC_OFS_ACTUAL, 32'h64);
    want <= 1'b1;
    step(AVC_OFS_HYST, 32'h2);
    for (k = 0; k < 80; k++) begin
      want <= 1'($random(seed));
      r = $unsigned($random(seed)) % 7;
      step(8'(r * 4), r == 0 ? $unsigned($random(seed)) % 8 : $random(seed) % 64);
    end
    ahb(1'b0, AVC_OFS_IRQ_STAT, 32'h0);
    chk("status", {29'h0, m_stat}, rd);
    ahb(1'b0, AVC_OFS_STATE, 32'h0);
    chk("state", {29'h0, en, m_ovf, m_match}, rd);
    ahb(1'b0, 8'h2C, 32'h0);
    chk("unmapped", 32'h0, rd);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("second reset", 32'h0, {ct, irq});
    print_verdict();
  end
endmodule : tb_top
